// File: include/epmc_pkg.sv
/*
 * Constants and types shared by the host-side controller for a 128K x 16 UV EPROM.
 * Assumes a single 100 MHz clock and pin-level modelling of the high voltages as enables.
 */
package epmc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned EPMC_AW = 17;
  localparam int unsigned EPMC_DW = 16;

  // ****************************************************************
  // Timing in ns and derived cycle counts
  // ****************************************************************
  localparam int unsigned EPMC_CLK_NS        = 10;
  localparam int unsigned EPMC_ACCESS_NS     = 250;
  localparam int unsigned EPMC_FLOAT_NS      = 60;
  localparam int unsigned EPMC_PGM_PULSE_NS  = 100000;
  localparam int unsigned EPMC_ACCESS_CYC    = (EPMC_ACCESS_NS + EPMC_CLK_NS - 1) / EPMC_CLK_NS;
  localparam int unsigned EPMC_FLOAT_CYC     = (EPMC_FLOAT_NS + EPMC_CLK_NS - 1) / EPMC_CLK_NS;
  localparam int unsigned EPMC_PGM_PULSE_CYC = (EPMC_PGM_PULSE_NS + EPMC_CLK_NS - 1) / EPMC_CLK_NS;
  localparam int unsigned EPMC_CW            = 14;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [EPMC_AW-1:0] EPMC_ADDR_RST      = 17'h00000;
  localparam int unsigned        EPMC_ID_MODE_BIT   = 9;
  localparam int unsigned        EPMC_ID_SEL_BIT    = 0;
  localparam int unsigned        EPMC_PARITY_BIT    = 7;

  // ****************************************************************
  // Commands and states
  // ****************************************************************
  typedef enum logic [2:0] {
    EPMC_CMD_READ   = 3'h0,
    EPMC_CMD_VERIFY = 3'h1,
    EPMC_CMD_PROG   = 3'h2,
    EPMC_CMD_ID     = 3'h3,
    EPMC_CMD_IDLE   = 3'h4
  } epmc_cmd_t;

  typedef enum logic [2:0] {
    EPMC_ST_IDLE  = 3'b000,
    EPMC_ST_SETUP = 3'b001,
    EPMC_ST_WAIT  = 3'b011,
    EPMC_ST_DONE  = 3'b010,
    EPMC_ST_FLOAT = 3'b110
  } epmc_state_t;

endpackage : epmc_pkg

// File: src/epmc_sync.sv
/*
 * Two-flip-flop synchroniser for the data pins read back from the memory.
 * Assumes the pins are asynchronous to clk.
 */
module epmc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : epmc_sync

// File: src/epmc_host.sv
/*
 * Host-side controller that drives a 128K x 16 UV EPROM through its pins:
 * read, program, program verify and identification cycles, one at a time.
 * Assumes the high programming supply and the elevated identification level
 * are switched by board circuits steered by the enable outputs here.
 */
// Behaviour
// [R1] To verify, chip-select and output-gate are low, program-strobe high and supply at its high level.
// [R2] Identification mode is entered only while the elevated level is held on the address line nine.
// [R3] In identification mode address bit zero low gives the maker byte, high the part byte.
// [R4] During identification every address line except bits zero and nine is held low.
// [R5] Each identifier byte has odd parity with its top bit as parity bit.
// [R6] Identifier bytes appear on the low data byte while chip-select and output-gate are low.
// [R7] The device drives the addressed word only while chip-select and output-gate are both low.
// [R8] With chip-select low and output-gate high the device data pins float.
// [R9] With chip-select high the device is in standby and its outputs float.
// [R10] Chip-select is the primary per-device select and output-gate follows the read strobe.
// [R11] Programming mode needs the high supply with chip-select and program-strobe low.
// [R12] Erased cells read as one and programming only turns ones into zeros.
// [R13] With high supply and chip-select high the device is not programmed and floats.
// [R14] The programmer presents all sixteen data bits in parallel while programming.
// [R15] In identification mode the upper data byte is undefined and ignored.
module epmc_host
  import epmc_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Command port
  input  wire logic                         cmd_valid,
  input  wire epmc_pkg::epmc_cmd_t          cmd_op,
  input  wire logic [epmc_pkg::EPMC_AW-1:0] cmd_addr,
  input  wire logic [epmc_pkg::EPMC_DW-1:0] cmd_wdata,
  output logic                              cmd_ready,
  output logic                              rsp_valid,
  output logic      [epmc_pkg::EPMC_DW-1:0] rsp_rdata,
  output logic                              rsp_parity_ok,
  output logic                              rsp_zero_to_one,
  // Memory pins
  output logic                              chip_sel_n,
  output logic                              out_gate_n,
  output logic                              program_strobe_n,
  output logic      [epmc_pkg::EPMC_AW-1:0] mem_addr,
  output logic                              program_supply_hi,
  output logic                              id_mode_address_line_hi,
  input  wire logic [epmc_pkg::EPMC_DW-1:0] data_i,
  output logic      [epmc_pkg::EPMC_DW-1:0] data_o,
  output logic                              data_oe_n
);
  import epmc_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [EPMC_DW-1:0] data_s;

  epmc_sync #(.W(EPMC_DW)) u_data_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .async_i (data_i),
    .sync_o  (data_s)
  );

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  epmc_state_t        st_q, st_d;
  epmc_cmd_t          op_q, op_d;
  logic [EPMC_CW-1:0] cnt_q, cnt_d;
  logic [EPMC_AW-1:0] addr_q, addr_d;
  logic [EPMC_DW-1:0] wdat_q, wdat_d;
  logic               ce_n_q, ce_n_d;
  logic               oe_n_q, oe_n_d;
  logic               pgm_n_q, pgm_n_d;
  logic               vpp_q, vpp_d;
  logic               vh_q, vh_d;
  logic               doe_n_q, doe_n_d;
  logic               rdy_q, rdy_d;
  logic               rv_q, rv_d;
  logic [EPMC_DW-1:0] rd_q, rd_d;
  logic               par_q, par_d;
  logic               z1_q, z1_d;

  localparam logic [EPMC_CW-1:0] ACC_C   = EPMC_CW'(EPMC_ACCESS_CYC + 2);
  localparam logic [EPMC_CW-1:0] FLOAT_C = EPMC_CW'(EPMC_FLOAT_CYC);
  localparam logic [EPMC_CW-1:0] PULSE_C = EPMC_CW'(EPMC_PGM_PULSE_CYC);

  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    ce_n_d  = ce_n_q;
    oe_n_d  = oe_n_q;
    pgm_n_d = pgm_n_q;
    vpp_d   = vpp_q;
    vh_d    = vh_q;
    doe_n_d = doe_n_q;
    rdy_d   = rdy_q;
    rv_d    = 1'b0;
    rd_d    = rd_q;
    par_d   = par_q;
    z1_d    = z1_q;
    case (st_q)
      EPMC_ST_IDLE: begin
        if (cmd_valid && rdy_q && cmd_op != EPMC_CMD_IDLE) begin
          op_d   = cmd_op;
          wdat_d = cmd_wdata;
          rdy_d  = 1'b0;
          cnt_d  = '0;
          st_d   = EPMC_ST_SETUP;
          if (cmd_op == EPMC_CMD_ID) begin
            addr_d = EPMC_ADDR_RST;                                       // see [R4]
            addr_d[EPMC_ID_SEL_BIT] = cmd_addr[EPMC_ID_SEL_BIT];          // see [R3]
            vh_d   = 1'b1;                                                // see [R2]
          end else begin
            addr_d = cmd_addr;
          end
          vpp_d = (cmd_op == EPMC_CMD_PROG) || (cmd_op == EPMC_CMD_VERIFY);
        end
      end
      EPMC_ST_SETUP: begin
        // Levels settle one cycle before any strobe moves.
        ce_n_d = 1'b0;                                                    // see [R10]
        if (op_q == EPMC_CMD_PROG) begin
          doe_n_d = 1'b0;                                                 // see [R14]
          pgm_n_d = 1'b0;                                                 // see [R11]
          cnt_d   = PULSE_C;
        end else begin
          oe_n_d  = 1'b0;                                                 // see [R7] [R1]
          pgm_n_d = 1'b1;
          cnt_d   = ACC_C;
        end
        st_d = EPMC_ST_WAIT;
      end
      EPMC_ST_WAIT: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - EPMC_CW'(1);
        end else begin
          st_d = EPMC_ST_DONE;
        end
      end
      EPMC_ST_DONE: begin
        if (op_q == EPMC_CMD_ID) begin
          rd_d = {8'h00, data_s[7:0]};                                    // see [R6] [R15]
          par_d = ^data_s[EPMC_PARITY_BIT:0];                             // see [R5]
        end else begin
          rd_d = data_s;
          par_d = 1'b1;
        end
        // A requested one where the cell holds zero cannot be programmed.
        z1_d = (op_q == EPMC_CMD_VERIFY) && |(wdat_q & ~data_s);          // see [R12]
        pgm_n_d = 1'b1;
        oe_n_d  = 1'b1;                                                   // see [R8]
        ce_n_d  = 1'b1;                                                   // see [R9] [R13]
        doe_n_d = 1'b1;
        cnt_d   = FLOAT_C;
        st_d    = EPMC_ST_FLOAT;
      end
      EPMC_ST_FLOAT: begin
        // The supplies drop only after the pins have floated.
        if (cnt_q != '0) begin
          cnt_d = cnt_q - EPMC_CW'(1);
        end else begin
          vpp_d = 1'b0;
          vh_d  = 1'b0;
          rv_d  = 1'b1;
          rdy_d = 1'b1;
          st_d  = EPMC_ST_IDLE;
        end
      end
      default: begin
        st_d = EPMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= EPMC_ST_IDLE;
      op_q    <= EPMC_CMD_IDLE;
      cnt_q   <= '0;
      addr_q  <= EPMC_ADDR_RST;
      wdat_q  <= '0;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      pgm_n_q <= 1'b1;
      vpp_q   <= 1'b0;
      vh_q    <= 1'b0;
      doe_n_q <= 1'b1;
      rdy_q   <= 1'b1;
      rv_q    <= 1'b0;
      rd_q    <= '0;
      par_q   <= 1'b0;
      z1_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      pgm_n_q <= pgm_n_d;
      vpp_q   <= vpp_d;
      vh_q    <= vh_d;
      doe_n_q <= doe_n_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      par_q   <= par_d;
      z1_q    <= z1_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready               = rdy_q;
  assign rsp_valid               = rv_q;
  assign rsp_rdata               = rd_q;
  assign rsp_parity_ok           = par_q;
  assign rsp_zero_to_one         = z1_q;
  assign chip_sel_n              = ce_n_q;
  assign out_gate_n              = oe_n_q;
  assign program_strobe_n        = pgm_n_q;
  assign mem_addr                = addr_q;
  assign program_supply_hi       = vpp_q;
  assign id_mode_address_line_hi = vh_q;
  assign data_o                  = wdat_q;
  assign data_oe_n               = doe_n_q;

endmodule : epmc_host

// File: test/epmc_host_monitor.sv
/*
 * Checker for the pin sequencing and command timing of the EPROM host controller.
 * Assumes it is bound to epmc_host and sees only that module's ports.
 */
module epmc_host_monitor
  import epmc_pkg::*;
(
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         sys_rst,
  // Command port
  input wire logic                         cmd_valid,
  input wire epmc_pkg::epmc_cmd_t          cmd_op,
  input wire logic                         cmd_ready,
  input wire logic                         rsp_valid,
  // Memory pins
  input wire logic                         chip_sel_n,
  input wire logic                         out_gate_n,
  input wire logic                         program_strobe_n,
  input wire logic [epmc_pkg::EPMC_AW-1:0] mem_addr,
  input wire logic                         program_supply_hi,
  input wire logic                         id_mode_address_line_hi,
  input wire logic                         data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rd_taken_s;
    cmd_valid && cmd_ready && cmd_op inside {EPMC_CMD_READ, EPMC_CMD_VERIFY, EPMC_CMD_ID};
  endsequence
  sequence prog_taken_s;
    cmd_valid && cmd_ready && cmd_op == EPMC_CMD_PROG;
  endsequence

  // The response register is set 37 edges after the taking edge and is seen on the 38th.
  read_answer_a: assert property (rd_taken_s |-> ##38 rsp_valid)
    else $error("read response late or missing");
  prog_drive_a: assert property (prog_taken_s |-> ##[1:3] (!program_strobe_n && !data_oe_n))
    else $error("program pulse not started");
  host_drive_a: assert property (!data_oe_n |->
    !chip_sel_n && !program_strobe_n && program_supply_hi && out_gate_n)
    else $error("host drives data outside programming");
  gate_select_a: assert property (!out_gate_n |-> !chip_sel_n && program_strobe_n)
    else $error("output gate low without select or with strobe");
  id_address_a: assert property (id_mode_address_line_hi |->
    mem_addr[16:1] == 16'h0000 && !program_supply_hi)
    else $error("identification address not clear");
  idle_standby_a: assert property (cmd_ready |-> chip_sel_n && program_strobe_n && data_oe_n)
    else $error("device selected while idle");
  resp_release_a: assert property (rsp_valid |->
    cmd_ready && !program_supply_hi && !id_mode_address_line_hi)
    else $error("supplies still applied at response");
  select_hold_a: assert property ($fell(chip_sel_n) |-> !chip_sel_n [*8])
    else $error("chip select dropped too soon");
endmodule : epmc_host_monitor

// File: test/epmc_mem_model.sv
/*
 * Behavioural model of the 128K x 16 memory seen from its pins; only 16 words are stored.
 * Assumes the host drives the pins synchronously to clk.
 */
module epmc_mem_model #(
  parameter logic [7:0] MAKER_ID = 8'h8a,  // Arbitrary value with odd parity.
  parameter logic [7:0] PART_ID  = 8'h23   // Arbitrary value with odd parity.
) (
  // Clock
  input  wire logic        clk,
  // Pins
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        program_strobe_n,
  input  wire logic [16:0] mem_addr,
  input  wire logic        program_supply_hi,
  input  wire logic        id_mode_address_line_hi,
  input  wire logic [15:0] data_o,
  input  wire logic        data_oe_n,
  output logic      [15:0] data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:15];
  logic [15:0] word;
  logic [15:0] last_q;
  logic        drive;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    last_q = 16'h0000;
  end
  assign drive = !chip_sel_n && !out_gate_n && program_strobe_n;
  assign word = id_mode_address_line_hi ? {8'h00, mem_addr[0] ? PART_ID : MAKER_ID}
                                        : mem[mem_addr[3:0]];
  // A floating bus shows the inverse of its last value so stale data cannot pass.
  assign data_i = drive ? word : ~last_q;
  always @(posedge clk) begin
    if (drive) last_q <= word;
    if (!chip_sel_n && !program_strobe_n && program_supply_hi && !data_oe_n)
      mem[mem_addr[3:0]] <= mem[mem_addr[3:0]] & data_o;
  end
endmodule : epmc_mem_model

// File: test/tb_top.sv
/*
 * Self-checking bench for the EPROM host controller with a memory model at its pins.
 * Assumes a 100 MHz clock; the whole run takes about 20300 cycles.
 */
module tb_top;
  import epmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MAKER = 8'h8a;  // Arbitrary value.
  localparam logic [7:0] PART  = 8'h23;  // Arbitrary value.
  logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
  epmc_cmd_t cmd_op = EPMC_CMD_IDLE;
  logic [16:0] cmd_addr = 17'h00000, mem_addr;
  logic [15:0] cmd_wdata = 16'h0000, rsp_rdata, data_i, data_o;
  logic cmd_ready, rsp_valid, rsp_parity_ok, rsp_zero_to_one, chip_sel_n, out_gate_n;
  logic program_strobe_n, program_supply_hi, id_mode_address_line_hi, data_oe_n;
  int failures = 0, tests_run = 0;

  always #5 clk = ~clk;

  epmc_host epmc_host_i (.clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
    .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_parity_ok, .rsp_zero_to_one, .chip_sel_n,
    .out_gate_n, .program_strobe_n, .mem_addr, .program_supply_hi,
    .id_mode_address_line_hi, .data_i, .data_o, .data_oe_n);
  epmc_mem_model #(.MAKER_ID(MAKER), .PART_ID(PART)) epmc_mem_model_i (.clk, .chip_sel_n,
    .out_gate_n, .program_strobe_n, .mem_addr, .program_supply_hi,
    .id_mode_address_line_hi, .data_o, .data_oe_n, .data_i);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_cmd(input epmc_cmd_t op, input logic [16:0] a, input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_addr  = a;
    cmd_wdata = w;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, rsp_valid}, 16'h0001);
  endtask : do_cmd

  task automatic sc_erased;
    do_cmd(EPMC_CMD_READ, 17'h00003, 16'h0000);
    check(rsp_rdata, 16'hffff);
  endtask : sc_erased

  task automatic sc_prog_verify;
    do_cmd(EPMC_CMD_PROG, 17'h00005, 16'ha5c3);
    do_cmd(EPMC_CMD_VERIFY, 17'h00005, 16'ha5c3);
    check(rsp_rdata, 16'ha5c3);
    check({15'h0000, rsp_zero_to_one}, 16'h0000);
    do_cmd(EPMC_CMD_PROG, 17'h00005, 16'hffff);
    do_cmd(EPMC_CMD_VERIFY, 17'h00005, 16'hffff);
    check(rsp_rdata, 16'ha5c3);
    check({15'h0000, rsp_zero_to_one}, 16'h0001);
  endtask : sc_prog_verify

  task automatic sc_ident;
    for (int i = 0; i < 2; i++) begin
      do_cmd(EPMC_CMD_ID, {16'hffff, i[0]}, 16'h0000);
      check(rsp_rdata, {8'h00, i[0] ? PART : MAKER});
      check({15'h0000, rsp_parity_ok}, 16'h0001);
    end
  endtask : sc_ident

  task automatic sc_refused;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op    = EPMC_CMD_IDLE;
    repeat (5) begin
      @(negedge clk);
      check({14'h0000, cmd_ready, chip_sel_n}, 16'h0003);
    end
    cmd_valid = 1'b0;
    do_cmd(EPMC_CMD_READ, 17'h00005, 16'h0000);
    check(rsp_rdata, 16'ha5c3);
    do_cmd(EPMC_CMD_READ, 17'h00003, 16'h0000);
    check(rsp_rdata, 16'hffff);
  endtask : sc_refused

  task automatic close_out;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    sc_erased();
    sc_prog_verify();
    sc_ident();
    sc_refused();
    close_out();
  end

  // Two programming pulses dominate the run; this leaves ample margin.
  initial begin
    #600000;
    failures++;
    close_out();
  end
endmodule : tb_top

bind epmc_host epmc_host_monitor epmc_host_monitor_i (.clk, .sys_rst, .cmd_valid, .cmd_op,
  .cmd_ready, .rsp_valid, .chip_sel_n, .out_gate_n, .program_strobe_n, .mem_addr,
  .program_supply_hi, .id_mode_address_line_hi, .data_oe_n);
